// ===== rtl/tlt_config_regs.sv
// Thermal assertion limit, tach pulse count and pin configuration registers
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "tlt_defines.svh"
module tlt_config_regs #(
    parameter int unsigned STEP_CYCLES = `TLT_STEP_CYCLES,
    parameter int          ADDR_W      = 10
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    thermalThrottlePin_n,
    output tlt_pkg::tlt_pulse_cfg_s      pulseCfg,
    output tlt_pkg::tlt_pin_cfg_s        pinCfg,
    output logic                         irq,
    output logic                         alertPinOut,
    output logic                         alertPinOe_n
);

    localparam logic [20:0] STEP_LAST = 21'(STEP_CYCLES - 1);
    localparam logic [7:0]  REPORT_MIN = 8'(`TLT_REPORT_MIN_STEPS);

    ////////////////////////////////////////////////////////////////////////////
    // Signals

    logic        thermSync;
    logic        thermAsserted;
    logic        thermAssertedPrev_ff;
    logic        assertRise;
    logic [20:0] stepCnt_ff;
    logic        stepTick;
    logic [7:0]  assertDurationCount_ff;
    logic [7:0]  nxt_assertDurationCount;
    logic        assertSeenFlag_ff;
    logic [7:0]  thermStatusView;
    logic        limitHit;
    logic [7:0]  assertLimitValue_ff;
    logic [7:0]  pulseCfgReg_ff;
    logic [7:0]  pinCfgReg_ff;
    logic [7:0]  intStatus_ff;
    logic [7:0]  intMask_ff;
    logic [7:0]  regIndex;
    logic        setupPhase;
    logic        accessDone;
    logic        writeDone;
    logic        readDone;
    logic        byteWrite;
    logic [7:0]  readValue;
    logic        addrHit;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        irq_ff;
    logic        alertPinOe_n_ff;
    logic        alertPinOut_ff;
    tlt_pkg::tlt_pulse_cfg_s pulseCfg_ff;
    tlt_pkg::tlt_pin_cfg_s   pinCfg_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser

    tlt_pin_sync #(
        .WIDTH     (1),
        .RESET_VAL (1'b1)
    ) uThermSync (
        .clk     (clk),
        .reset_n (reset_n),
        .pinIn   (thermalThrottlePin_n),
        .syncOut (thermSync)
    );

    assign thermAsserted = ~thermSync;
    assign assertRise    = thermAsserted & ~thermAssertedPrev_ff;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            thermAssertedPrev_ff <= 1'b0;
        end else begin
            thermAssertedPrev_ff <= thermAsserted;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    assign regIndex   = paddr[9:2];
    assign setupPhase = psel & ~penable;
    assign accessDone = psel & penable & pready_ff;
    assign writeDone  = accessDone & pwrite & ~pslverr_ff;
    assign readDone   = accessDone & ~pwrite & ~pslverr_ff;
    assign byteWrite  = writeDone & pstrb[0];

    always_comb begin
        readValue = 8'h00;
        addrHit   = 1'b1;
        unique case (regIndex)
            `TLT_IDX_INT_STATUS2:  readValue = intStatus_ff;
            `TLT_IDX_INT_MASK2:    readValue = intMask_ff;
            `TLT_IDX_THERMAL_THROTTLE_PIN_STATUS: readValue = thermStatusView;
            `TLT_IDX_ASSERT_LIMIT: readValue = assertLimitValue_ff;
            `TLT_IDX_PULSE_CFG:    readValue = pulseCfgReg_ff;
            `TLT_IDX_PIN_CFG:      readValue = pinCfgReg_ff & `TLT_PIN_CFG_WMASK;
            `TLT_IDX_TEST_ONE:     readValue = `TLT_RST_TEST;
            `TLT_IDX_TEST_TWO:     readValue = `TLT_RST_TEST;
            default:               addrHit   = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB answer

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff <= setupPhase;
            if (setupPhase) begin
                pslverr_ff <= ~addrHit;
                prdata_ff  <= pwrite ? 32'h0000_0000 : {24'h00_0000, readValue};
            end else if (accessDone) begin
                pslverr_ff <= 1'b0;
                prdata_ff  <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            assertLimitValue_ff <= `TLT_RST_ASSERT_LIMIT;
        end else if (byteWrite && regIndex == `TLT_IDX_ASSERT_LIMIT) begin
            assertLimitValue_ff <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pulseCfgReg_ff <= `TLT_RST_PULSE_CFG;
        end else if (byteWrite && regIndex == `TLT_IDX_PULSE_CFG) begin
            pulseCfgReg_ff <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinCfgReg_ff <= `TLT_RST_PIN_CFG;
        end else if (byteWrite && regIndex == `TLT_IDX_PIN_CFG) begin
            pinCfgReg_ff <= pwdata[7:0] & `TLT_PIN_CFG_WMASK;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            intMask_ff <= `TLT_RST_INT_MASK2;
        end else if (byteWrite && regIndex == `TLT_IDX_INT_MASK2) begin
            intMask_ff <= pwdata[7:0] & `TLT_INT_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration outputs

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pulseCfg_ff <= tlt_pkg::tlt_pulse_cfg_s'(`TLT_RST_PULSE_CFG);
            pinCfg_ff   <= '{tlt_pkg::TLT_THR_20MV, 1'b0, 1'b1};
        end else begin
            pulseCfg_ff <= tlt_pkg::tlt_pulse_cfg_s'(pulseCfgReg_ff);
            pinCfg_ff.twoWireThresholdSel <=
                tlt_pkg::tlt_threshold_e'(pinCfgReg_ff[`TLT_THR_MSB:`TLT_THR_LSB]);
            pinCfg_ff.alertPinSelect <= pinCfgReg_ff[`TLT_BIT_ALERT_SEL];
            pinCfg_ff.measureInputEn <= ~pinCfgReg_ff[`TLT_BIT_ALERT_SEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertion step timer

    assign stepTick = thermAsserted && (stepCnt_ff == STEP_LAST);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stepCnt_ff <= 21'h00_0000;
        end else if (!thermAsserted || stepTick) begin
            stepCnt_ff <= 21'h00_0000;
        end else begin
            stepCnt_ff <= stepCnt_ff + 21'h00_0001;
        end
    end

    always_comb begin
        nxt_assertDurationCount = assertDurationCount_ff;
        if (readDone && regIndex == `TLT_IDX_THERMAL_THROTTLE_PIN_STATUS) begin
            nxt_assertDurationCount = 8'h00;
        end
        if (stepTick && nxt_assertDurationCount != 8'hFF) begin
            nxt_assertDurationCount = nxt_assertDurationCount + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            assertDurationCount_ff <= 8'h00;
        end else begin
            assertDurationCount_ff <= nxt_assertDurationCount;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            assertSeenFlag_ff <= 1'b0;
        end else if (thermAsserted) begin
            assertSeenFlag_ff <= 1'b1;
        end else if (readDone && regIndex == `TLT_IDX_THERMAL_THROTTLE_PIN_STATUS) begin
            assertSeenFlag_ff <= 1'b0;
        end
    end

    // Upper bits stay zero until the second step
    assign thermStatusView = (assertDurationCount_ff >= REPORT_MIN) ?
                             assertDurationCount_ff :
                             {7'h00, assertSeenFlag_ff};

    ////////////////////////////////////////////////////////////////////////////
    // Limit comparison and interrupt status

    always_comb begin
        limitHit = 1'b0;
        if (assertLimitValue_ff == 8'h00) begin
            limitHit = assertRise;
        end else if (stepTick) begin
            limitHit = ({1'b0, assertDurationCount_ff} + 9'h001) >
                       {1'b0, assertLimitValue_ff};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            intStatus_ff <= `TLT_RST_INT_STATUS2;
        end else if (limitHit) begin
            intStatus_ff[`TLT_BIT_TIMER_EVENT] <= 1'b1;
        end else if (byteWrite && regIndex == `TLT_IDX_INT_STATUS2) begin
            intStatus_ff <= intStatus_ff & ~(pwdata[7:0] & `TLT_INT_WMASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt and alert pin

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_ff          <= 1'b0;
            alertPinOe_n_ff <= 1'b1;
            alertPinOut_ff  <= 1'b0;
        end else begin
            irq_ff          <= |(intStatus_ff & ~intMask_ff);
            alertPinOe_n_ff <= ~(pinCfgReg_ff[`TLT_BIT_ALERT_SEL] &
                                 |(intStatus_ff & ~intMask_ff));
            alertPinOut_ff  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata       = prdata_ff;
    assign pready       = pready_ff;
    assign pslverr      = pslverr_ff;
    assign pulseCfg     = pulseCfg_ff;
    assign pinCfg       = pinCfg_ff;
    assign irq          = irq_ff;
    assign alertPinOut  = alertPinOut_ff;
    assign alertPinOe_n = alertPinOe_n_ff;

endmodule : tlt_config_regs

// ===== rtl/tlt_defines.svh
// Register indices, field positions, reset values and timing counts
`ifndef TLT_DEFINES_SVH
`define TLT_DEFINES_SVH

// Register indices, byte address is four times the index
`define TLT_IDX_INT_STATUS2   8'h42
`define TLT_IDX_INT_MASK2     8'h75
`define TLT_IDX_THERMAL_THROTTLE_PIN_STATUS  8'h79
`define TLT_IDX_ASSERT_LIMIT  8'h7A
`define TLT_IDX_PULSE_CFG     8'h7B
`define TLT_IDX_PIN_CFG       8'h7D
`define TLT_IDX_TEST_ONE      8'h7E
`define TLT_IDX_TEST_TWO      8'h7F

// Reset values
`define TLT_RST_ASSERT_LIMIT  8'h00
`define TLT_RST_PULSE_CFG     8'h55
`define TLT_RST_PIN_CFG       8'h00
`define TLT_RST_TEST          8'h00
`define TLT_RST_INT_STATUS2   8'h00
`define TLT_RST_INT_MASK2     8'h00

// Field positions
`define TLT_BIT_TIMER_EVENT   5
`define TLT_BIT_ALERT_SEL     0
`define TLT_THR_LSB           2
`define TLT_THR_MSB           3
`define TLT_PIN_CFG_WMASK     8'h0D
`define TLT_INT_WMASK         8'h20

// Timing
`define TLT_CLK_PERIOD_NS     20
`define TLT_STEP_TIME_NS      22760000
`define TLT_REPORT_TIME_NS    45520000
`define TLT_STEP_CYCLES       (`TLT_STEP_TIME_NS / `TLT_CLK_PERIOD_NS)
`define TLT_REPORT_MIN_STEPS  (`TLT_REPORT_TIME_NS / `TLT_STEP_TIME_NS)

`endif

// ===== rtl/tlt_pkg.sv
// Types shared by the thermal limit and tach configuration block
package tlt_pkg;

    typedef enum logic [1:0] {
        TLT_PULSES_ONE   = 2'b00,
        TLT_PULSES_TWO   = 2'b01,
        TLT_PULSES_THREE = 2'b10,
        TLT_PULSES_FOUR  = 2'b11
    } tlt_pulse_cnt_e;

    typedef enum logic [1:0] {
        TLT_THR_20MV  = 2'b00,
        TLT_THR_40MV  = 2'b01,
        TLT_THR_80MV  = 2'b10,
        TLT_THR_130MV = 2'b11
    } tlt_threshold_e;

    typedef struct packed {
        tlt_pulse_cnt_e fanFourPulseSel;
        tlt_pulse_cnt_e fanThreePulseSel;
        tlt_pulse_cnt_e fanTwoPulseSel;
        tlt_pulse_cnt_e fanOnePulseSel;
    } tlt_pulse_cfg_s;

    typedef struct packed {
        tlt_threshold_e twoWireThresholdSel;
        logic           alertPinSelect;
        logic           measureInputEn;
    } tlt_pin_cfg_s;

endpackage : tlt_pkg

// ===== rtl/tlt_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module tlt_pin_sync #(
    parameter int          WIDTH     = 1,
    parameter logic [0:0]  RESET_VAL = 1'b1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] syncOut
);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gBit
            logic stageOne_ff;
            logic stageTwo_ff;
            logic stageThree_ff;
            logic value_ff;

            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    stageOne_ff   <= RESET_VAL;
                    stageTwo_ff   <= RESET_VAL;
                    stageThree_ff <= RESET_VAL;
                    value_ff      <= RESET_VAL;
                end else begin
                    stageOne_ff   <= pinIn[g];
                    stageTwo_ff   <= stageOne_ff;
                    stageThree_ff <= stageTwo_ff;
                    if (stageTwo_ff == stageThree_ff) begin
                        value_ff <= stageThree_ff;
                    end
                end
            end

            assign syncOut[g] = value_ff;
        end
    endgenerate

endmodule : tlt_pin_sync

// ===== dv/tlt_host_model.sv
// Host model issuing register transfers on the peripheral bus
`timescale 1ns/1ps
module tlt_host_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [9:0]       paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
    end
    ////////////////////////////////////////
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                        input logic [3:0] st, output logic [31:0] rd, output logic err);
        logic wrOk;
        wrOk = w && (idx[7:1] != 7'h3F);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wrOk;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h0, wd};
        pstrb <= st;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask : xfer
endmodule : tlt_host_model

// ===== dv/tlt_config_regs_properties.sv
// Port checker for the configuration register block
`timescale 1ns/1ps
module tlt_config_regs_checker #(
    parameter int unsigned STEP_CYCLES = 8,
    parameter int          ADDR_W      = 10
) (
    input wire logic                    clk,
    input wire logic                    reset_n,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [ADDR_W-1:0]       paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [3:0]              pstrb,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    thermalThrottlePin_n,
    input wire tlt_pkg::tlt_pulse_cfg_s pulseCfg,
    input wire tlt_pkg::tlt_pin_cfg_s   pinCfg,
    input wire logic                    irq,
    input wire logic                    alertPinOut,
    input wire logic                    alertPinOe_n
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    wire       wrAcc  = psel & penable & pready & pwrite & pstrb[0];
    wire       rdSet  = psel & !penable & !pwrite;
    wire [7:0] regIdx = paddr[9:2];
    ////////////////////////////////////////
    property p_pulse_rst;
        $rose(reset_n) |-> pulseCfg == 8'h55;
    endproperty
    a_pulse_rst: assert property (p_pulse_rst) else $error("pulse reset");
    property p_pulse_wr;
        wrAcc && regIdx == 8'h7B |=> ##1 pulseCfg == $past(pwdata[7:0], 2);
    endproperty
    a_pulse_wr: assert property (p_pulse_wr) else $error("pulse write");
    property p_pin_wr;
        wrAcc && regIdx == 8'h7D |=> ##1
            pinCfg == {$past(pwdata[3:2], 2), $past(pwdata[0], 2), !$past(pwdata[0], 2)};
    endproperty
    a_pin_wr: assert property (p_pin_wr) else $error("pin write");
    property p_alert_drv;
        irq && pinCfg.alertPinSelect && $past(pinCfg.alertPinSelect) |-> !alertPinOe_n;
    endproperty
    a_alert_drv: assert property (p_alert_drv) else $error("alert idle");
    property p_alert_idle;
        !irq |-> alertPinOe_n && !alertPinOut;
    endproperty
    a_alert_idle: assert property (p_alert_idle) else $error("alert driven");
    property p_rsv_rd;
        rdSet && regIdx == 8'h7D |=> pready && (prdata & 32'hFFFF_FFF2) == 0;
    endproperty
    a_rsv_rd: assert property (p_rsv_rd) else $error("reserved bits");
    property p_test_rd;
        rdSet && regIdx[7:1] == 7'h3F |=> pready && !pslverr && prdata == 0;
    endproperty
    a_test_rd: assert property (p_test_rd) else $error("test reg");
    property p_irq_fall;
        $fell(irq) |-> $past(wrAcc, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
endmodule : tlt_config_regs_checker

bind tlt_config_regs tlt_config_regs_checker #(.STEP_CYCLES(STEP_CYCLES), .ADDR_W(ADDR_W))
    u_chk (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .thermalThrottlePin_n, .pulseCfg, .pinCfg, .irq, .alertPinOut,
    .alertPinOe_n);

// ===== dv/tlt_config_regs_tb_top.sv
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
module tlt_config_regs_tb_top;
    localparam int STEP = 8;
    logic                    clk = 1'h0;
    logic                    reset_n = 1'h0;
    logic                    thermPinN = 1'h1;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [9:0]              paddr;
    logic [31:0]             pwdata;
    logic [3:0]              pstrb;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    irq;
    logic                    alertPinOut;
    logic                    alertPinOe_n;
    tlt_pkg::tlt_pulse_cfg_s pulseCfg;
    tlt_pkg::tlt_pin_cfg_s   pinCfg;
    logic [31:0]             rdv;
    logic                    err;
    logic [3:0]              pinExp;
    int                      mdl [256];
    int                      regList [$] = '{8'h42, 8'h75, 8'h79, 8'h7A, 8'h7B, 8'h7D,
                                             8'h7E, 8'h7F, 8'h10};
    int                      failures = 0;
    int                      samplesChecked = 0;
    int                      cycles = 0;
    int                      seed = 5615;
    tlt_host_model u_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr);
    tlt_config_regs #(.STEP_CYCLES(STEP)) dut (.clk, .reset_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .thermalThrottlePin_n(thermPinN), .pulseCfg, .pinCfg, .irq, .alertPinOut,
        .alertPinOe_n);
    ////////////////////////////////////////
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic logic known(int i);
        return i inside {8'h42, 8'h75, 8'h79, 8'h7A, 8'h7B, 8'h7D, 8'h7E, 8'h7F};
    endfunction : known
    function automatic int wmask(int i);
        case (i)
            8'h7A, 8'h7B: return 8'hFF;
            8'h7D: return 8'h0D;
            8'h75: return 8'h20;
            default: return 0;
        endcase
    endfunction : wmask
    task automatic acc(logic w, int i, int v, logic [3:0] st = 4'hF);
        u_host.xfer(w, i[7:0], v[7:0], st, rdv, err);
        chk("slave error", err, known(i) ? 0 : 1);
        if (!w) begin
            chk($sformatf("reg %h", i), rdv, known(i) ? mdl[i] : 0);
            if (i == 8'h79)
                mdl[i] = 0;
        end else if (st[0] && i == 8'h42)
            mdl[i] &= ~(v & 8'h20);
        else if (st[0])
            mdl[i] = (mdl[i] & ~wmask(i)) | (v & wmask(i));
    endtask : acc
    initial begin
        foreach (mdl[i]) mdl[i] = 0;
        mdl[8'h7B] = 8'h55;
        repeat (5) @(posedge clk);
        reset_n <= 1'h1;
        chk("pulseCfg", pulseCfg, 8'h55);
        foreach (regList[k]) acc(0, regList[k], 0);
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            acc(1, 8'h7B, c * 8'h55);
            repeat (2) @(posedge clk);
            chk("fanFour", pulseCfg.fanFourPulseSel, c);
            chk("fanOne", pulseCfg.fanOnePulseSel, c);
            chk("pulseAll", pulseCfg, c * 8'h55);
            acc(1, 8'h7D, c << 2);
            repeat (2) @(posedge clk);
            chk("threshold", pinCfg.twoWireThresholdSel, c);
            chk("measureEn", pinCfg.measureInputEn, 1);
            chk("alertSel", pinCfg.alertPinSelect, 0);
        end
        acc(1, 8'h7A, 8'hA5, 4'hE);
        acc(0, 8'h7A, 0);
        repeat (4) begin
            acc(1, 8'h7B, $random(seed));
            acc(1, 8'h7A, $random(seed));
            acc(1, 8'h7D, $random(seed));
            acc(1, 8'h7E, $random(seed));
            foreach (regList[k]) acc(0, regList[k], 0);
            chk("pulseCfgRnd", pulseCfg, mdl[8'h7B]);
            pinExp = {mdl[8'h7D][3:2], mdl[8'h7D][0], ~mdl[8'h7D][0]};
            chk("pinCfgRnd", pinCfg, pinExp);
        end
        $display("test config done");
        acc(1, 8'h7D, 8'h01);
        acc(1, 8'h7A, 0);
        thermPinN <= 1'h0;
        repeat (8) @(posedge clk);
        thermPinN <= 1'h1;
        repeat (3) @(posedge clk);
        mdl[8'h42] = 8'h20;
        mdl[8'h79] = 1;
        acc(0, 8'h42, 0);
        chk("irq", irq, 1);
        chk("alertOe", alertPinOe_n, 0);
        acc(1, 8'h75, 8'h20);
        repeat (2) @(posedge clk);
        chk("irqMasked", irq, 0);
        chk("alertMasked", alertPinOe_n, 1);
        acc(1, 8'h75, 0);
        acc(1, 8'h42, 8'h20);
        repeat (2) @(posedge clk);
        chk("irqCleared", irq, 0);
        acc(0, 8'h79, 0);
        acc(0, 8'h79, 0);
        $display("test limit zero done");
        acc(1, 8'h7A, 3);
        thermPinN <= 1'h0;
        repeat (30) @(posedge clk);
        acc(0, 8'h42, 0);
        repeat (10) @(posedge clk);
        thermPinN <= 1'h1;
        repeat (10) @(posedge clk);
        mdl[8'h42] = 8'h20;
        mdl[8'h79] = 5;
        acc(0, 8'h42, 0);
        acc(0, 8'h79, 0);
        acc(0, 8'h79, 0);
        acc(1, 8'h42, 8'h20);
        $display("test limit three done");
        reset_n <= 1'h0;
        repeat (2) @(posedge clk);
        reset_n <= 1'h1;
        foreach (mdl[i]) mdl[i] = 0;
        mdl[8'h7B] = 8'h55;
        acc(0, 8'h7B, 0);
        acc(0, 8'h7D, 0);
        $display("test second reset done");
        close_out();
    end
endmodule : tlt_config_regs_tb_top
